// [hw/sfp_pkg.sv]
// constants of the serial-flash discovery table and power-up sequencing
// assumes a 100 MHz system clock that samples the serial pins
//
// Operation
// [RQ1] table advertises reset 99h after enable 66h
// [RQ2] wrap read opcode C0h in bits 23:16
// [RQ3] wrap length field reads 64h
// [RQ4] block lock supported, opcode 36h bits 09:02
// [RQ5] lock type bit reads 0, volatile
// [RQ6] bit 10 reads 0, locks power-up protected
// [RQ7] maximum supply 2000h at 61h:60h
// [RQ8] minimum supply 1650h at 63h:62h
// [RQ9] unused table locations read FFh
// [RQ10] table read only in 1-1-1, 2-2-2, 4-4-4
// [RQ11] power-up in standby, not deep power-down
// [RQ12] write enable latch cleared at power-up
// [RQ13] below lockout threshold, held reset, commands ignored
// [RQ14] writes wait for both power-up delays
// [RQ15] reads allowed after select delay alone
// [RQ16] host keeps select inactive during power transitions
// [RQ17] table is fixed, read only
package sfp_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS     = 10;
	localparam int unsigned WRITE_READY_US    = 1000;
	localparam int unsigned SELECT_READY_US   = 800;
	localparam int unsigned WRITE_READY_CYC   = (WRITE_READY_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int unsigned SELECT_READY_CYC  = (SELECT_READY_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// table layout
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_SUPPLY_WORD   = 8'h60;
	localparam logic [7:0]  OFS_RESET_WORD    = 8'h64;
	localparam logic [7:0]  OFS_LOCK_WORD     = 8'h68;
	localparam logic [7:0]  OFS_TAIL_WORD     = 8'h6C;
	localparam logic [7:0]  BLANK_BYTE        = 8'hFF;
	localparam logic [15:0] SUPPLY_MAX_BCD    = 16'h2000;
	localparam logic [15:0] SUPPLY_MIN_BCD    = 16'h1650; // RQ8
	localparam logic [7:0]  RESET_OPCODE      = 8'h99;
	localparam logic [7:0]  RESET_ENABLE_OP   = 8'h66;
	localparam logic [7:0]  WRAP_OPCODE       = 8'hC0; // RQ2
	localparam logic [7:0]  WRAP_LENGTH       = 8'h64; // RQ3
	localparam logic [7:0]  LOCK_OPCODE       = 8'h36;
	localparam logic        LOCK_NONVOLATILE  = 1'b0; // RQ5
	localparam logic        LOCK_UNPROTECTED  = 1'b0; // RQ6

	localparam logic [31:0] SUPPLY_WORD = {SUPPLY_MIN_BCD, SUPPLY_MAX_BCD};
	// wrap, spare, erase/program suspend, reset opcode, reset, deep down, hold, hw reset
	localparam logic [31:0] RESET_WORD  = {WRAP_LENGTH, WRAP_OPCODE, 4'hF, RESET_OPCODE,
		4'hC};
	// spare, permanent, read lock, otp, default, opcode, type, lock
	localparam logic [31:0] LOCK_WORD   = {16'hFFFF, 2'h3, 1'h0, 1'h0, 1'h1, LOCK_UNPROTECTED,
		LOCK_OPCODE, LOCK_NONVOLATILE, 1'h1};
	localparam logic [31:0] TAIL_WORD   = 32'hFFFFFFFF;

	// ----------------------------------------------------------------
	// command opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] READ_TABLE_CMD        = 8'h5A;
	localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
	localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
	localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
	localparam logic [7:0] PAGE_PROGRAM_CMD      = 8'h02;
	localparam logic [7:0] QUAD_PAGE_PROGRAM_CMD = 8'h38;
	localparam logic [7:0] BLOCK4K_WIPE_CMD      = 8'h20;
	localparam logic [7:0] HALF_BLOCK_WIPE_CMD   = 8'h52;
	localparam logic [7:0] BLOCK_WIPE_CMD        = 8'hD8;
	localparam logic [7:0] CHIP_WIPE_CMD         = 8'hC7;
	localparam logic [7:0] CHIP_WIPE_ALT_CMD     = 8'h60;
	localparam logic [7:0] STATUS_REG_WRITE_CMD  = 8'h01;
	localparam logic [7:0] SECURITY_REG_WRITE_CMD = 8'h2F;
	localparam logic [7:0] DEEP_DOWN_CMD         = 8'hB9;
	localparam logic [7:0] WAKE_CMD              = 8'hAB;
	localparam logic [7:0] QUAD_ENTER_CMD        = 8'h35;
	localparam logic [7:0] QUAD_EXIT_CMD         = 8'hF5;

	localparam logic [4:0] OPCODE_BITS  = 5'd8;
	localparam logic [4:0] ADDR_BITS    = 5'd24;
	localparam logic [4:0] DUMMY_CLKS   = 5'd8;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CMD   = 3'b001,
		ST_ADDR  = 3'b010,
		ST_DUMMY = 3'b011,
		ST_DATA  = 3'b100,
		ST_DONE  = 3'b101,
		ST_SKIP  = 3'b110
	} sfp_state_e;

endpackage : sfp_pkg

// [hw/sfp_sync.sv]
// two-stage synchroniser bank for pins sampled by the system clock
// assumes every bit is an independent level from outside the domain
`timescale 1ns/1ps
module sfp_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_r <= INIT;
			dout   <= INIT;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule : sfp_sync

// [hw/sfp_param_rom.sv]
// fixed discovery parameter table, upper part, byte wide with registered read
// assumes byte addresses inside the 256-byte table space
`timescale 1ns/1ps
module sfp_param_rom (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [7:0] addr,
	input  wire logic       inSpace,
	output logic      [7:0] data
);
	logic [31:0] word;

	// no write path exists: contents are constants
	always_comb begin
		word = sfp_pkg::TAIL_WORD;
		unique case ({addr[7:2], 2'b00})
			sfp_pkg::OFS_SUPPLY_WORD: word = sfp_pkg::SUPPLY_WORD; // RQ7
			sfp_pkg::OFS_RESET_WORD:  word = sfp_pkg::RESET_WORD;  // RQ1
			sfp_pkg::OFS_LOCK_WORD:   word = sfp_pkg::LOCK_WORD;   // RQ4
			default:                  word = sfp_pkg::TAIL_WORD;   // RQ9
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			data <= sfp_pkg::BLANK_BYTE;
		else if (!inSpace)
			data <= sfp_pkg::BLANK_BYTE; // RQ9
		else
			data <= word[{addr[1:0], 3'b000} +: 8]; // RQ17
	end
endmodule : sfp_param_rom

// [hw/sfp_flash_front.sv]
// serial flash front end: command sequencer, table reads, write latch and power-up gating
// assumes rst_n is the supply power-on reset and the serial pins are mode 0
`timescale 1ns/1ps
module sfp_flash_front #(
	parameter int unsigned WRITE_READY_CYC  = sfp_pkg::WRITE_READY_CYC,
	parameter int unsigned SELECT_READY_CYC = sfp_pkg::SELECT_READY_CYC
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       sclk,
	input  wire logic       csN,
	input  wire logic [3:0] sioIn,
	input  wire logic       supplyMinOk,
	output logic      [3:0] sioOut,
	output logic      [3:0] sioOe,
	output logic            writeLatch,
	output logic            deepDown,
	output logic            quadMode,
	output logic            readReady,
	output logic            writeReady
);
	// ----------------------------------------------------------------
	// pin sampling
	// ----------------------------------------------------------------
	logic [6:0]  pinSync;
	logic        sclkS;
	logic        csNS;
	logic [3:0]  sioS;
	logic        supS;
	logic        sclkPrev_r;
	logic        csPrev_r;
	logic        sclkRise;
	logic        sclkFall;
	logic        csFall;
	logic        csRise;

	sfp_sync #(
		.WIDTH (7),
		.INIT  (7'h02)
	) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.din   ({supplyMinOk, sioIn, csN, sclk}),
		.dout  (pinSync)
	);

	assign sclkS = pinSync[0];
	assign csNS  = pinSync[1];
	assign sioS  = pinSync[5:2];
	assign supS  = pinSync[6];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sclkPrev_r <= 1'b0;
			csPrev_r   <= 1'b1;
		end else begin
			sclkPrev_r <= sclkS;
			csPrev_r   <= csNS;
		end
	end

	// edges count only while selected, so a free-running host clock is ignored
	assign sclkRise = sclkS & ~sclkPrev_r & ~csNS;
	assign sclkFall = ~sclkS & sclkPrev_r & ~csNS;
	assign csFall   = ~csNS & csPrev_r;
	assign csRise   = csNS & ~csPrev_r;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [23:0] shiftIn(input logic [23:0] sh, input logic [3:0] sio,
		input logic quad);
		shiftIn = quad ? {sh[19:0], sio} : {sh[22:0], sio[0]};
	endfunction : shiftIn

	// single mode answers on the second lane only
	function automatic logic [3:0] laneOut(input logic [7:0] b, input logic quad);
		laneOut = quad ? b[7:4] : {2'b00, b[7], 1'b0};
	endfunction : laneOut

	// everything that programs, erases or rewrites a register is write-class
	function automatic logic isWriteCmd(input logic [7:0] op);
		unique case (op)
			sfp_pkg::PAGE_PROGRAM_CMD,
			sfp_pkg::QUAD_PAGE_PROGRAM_CMD,
			sfp_pkg::BLOCK4K_WIPE_CMD,
			sfp_pkg::HALF_BLOCK_WIPE_CMD,
			sfp_pkg::BLOCK_WIPE_CMD,
			sfp_pkg::CHIP_WIPE_CMD,
			sfp_pkg::CHIP_WIPE_ALT_CMD,
			sfp_pkg::STATUS_REG_WRITE_CMD,
			sfp_pkg::SECURITY_REG_WRITE_CMD: isWriteCmd = 1'b1;
			default:                         isWriteCmd = 1'b0;
		endcase
	endfunction : isWriteCmd

	// ----------------------------------------------------------------
	// power-up delays
	// ----------------------------------------------------------------
	// rst_n low is the supply below the lockout threshold, so everything clears
	logic [31:0] writeCnt_r;
	logic [31:0] selectCnt_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			writeCnt_r <= 32'h00000000; // RQ13
			writeReady <= 1'b0;
		end else begin
			if (writeCnt_r < WRITE_READY_CYC)
				writeCnt_r <= writeCnt_r + 32'h00000001;
			// both delays must have passed before write-class commands
			// the supply term drops it in the same cycle as readReady on a dip
			writeReady <= (writeCnt_r >= WRITE_READY_CYC) && readReady && supS; // RQ14
		end
	end

	// a dip below the supply minimum restarts the select delay
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			selectCnt_r <= 32'h00000000;
			readReady   <= 1'b0;
		end else if (!supS) begin
			selectCnt_r <= 32'h00000000;
			readReady   <= 1'b0;
		end else begin
			if (selectCnt_r < SELECT_READY_CYC)
				selectCnt_r <= selectCnt_r + 32'h00000001;
			readReady <= selectCnt_r >= SELECT_READY_CYC; // RQ15
		end
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	sfp_pkg::sfp_state_e state_r;
	logic [23:0] inSh_r;
	logic [4:0]  bitCnt_r;
	logic [7:0]  op_r;
	logic [23:0] addr_r;
	logic        srcStatus_r;
	logic [23:0] nextSh;
	logic [4:0]  step;
	logic [4:0]  nextCnt;
	logic [7:0]  opcode;
	logic        execNow;

	assign step    = quadMode ? 5'd4 : 5'd1;
	assign nextSh  = shiftIn(inSh_r, sioS, quadMode);
	assign nextCnt = bitCnt_r + step;
	assign opcode  = nextSh[7:0];
	assign execNow = csRise && (state_r == sfp_pkg::ST_DONE);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r     <= sfp_pkg::ST_IDLE;
			inSh_r      <= 24'h000000;
			bitCnt_r    <= 5'h00;
			op_r        <= 8'h00;
			srcStatus_r <= 1'b0;
		end else if (csRise) begin
			state_r <= sfp_pkg::ST_IDLE;
		end else if (csFall) begin
			// selection before the select delay is answered with nothing
			state_r  <= readReady ? sfp_pkg::ST_CMD : sfp_pkg::ST_SKIP; // RQ13
			bitCnt_r <= 5'h00;
		end else if (!readReady) begin
			// a supply dip inside a frame voids the rest of it
			state_r <= sfp_pkg::ST_SKIP; // RQ13
		end else if (sclkRise) begin
			unique case (state_r)
				sfp_pkg::ST_CMD: begin
					inSh_r   <= nextSh;
					bitCnt_r <= nextCnt;
					if (nextCnt == sfp_pkg::OPCODE_BITS) begin
						op_r     <= opcode;
						bitCnt_r <= 5'h00;
						if (deepDown)
							state_r <= (opcode == sfp_pkg::WAKE_CMD) ? sfp_pkg::ST_DONE
								: sfp_pkg::ST_SKIP;
						else if (opcode == sfp_pkg::READ_TABLE_CMD)
							// only single and quad pin modes exist here, both legal
							state_r <= sfp_pkg::ST_ADDR; // RQ10
						else if (opcode == sfp_pkg::STATUS_READ_CMD) begin
							state_r     <= sfp_pkg::ST_DATA;
							srcStatus_r <= 1'b1;
						end else
							state_r <= sfp_pkg::ST_DONE;
					end
				end
				sfp_pkg::ST_ADDR: begin
					inSh_r   <= nextSh;
					bitCnt_r <= nextCnt;
					if (nextCnt == sfp_pkg::ADDR_BITS) begin
						state_r  <= sfp_pkg::ST_DUMMY;
						bitCnt_r <= 5'h00;
					end
				end
				sfp_pkg::ST_DUMMY: begin
					bitCnt_r <= bitCnt_r + 5'd1;
					if (bitCnt_r == sfp_pkg::DUMMY_CLKS - 5'd1) begin
						state_r     <= sfp_pkg::ST_DATA;
						srcStatus_r <= 1'b0;
					end
				end
				// extra clocks after a complete opcode void it
				sfp_pkg::ST_DONE: state_r <= sfp_pkg::ST_SKIP;
				sfp_pkg::ST_IDLE,
				sfp_pkg::ST_DATA,
				sfp_pkg::ST_SKIP: state_r <= state_r;
				default: state_r <= sfp_pkg::ST_SKIP;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// executed command decode
	// ----------------------------------------------------------------
	// one decode feeds the latch and the mode flags, so both act on the same frame
	logic rstArm_r;
	logic doSetLatch;
	logic doClearLatch;
	logic doWrite;
	logic doSoftReset;
	logic doDeepDown;
	logic doWake;
	logic doQuadEnter;
	logic doQuadExit;

	always_comb begin
		doSetLatch   = 1'b0;
		doClearLatch = 1'b0;
		doWrite      = 1'b0;
		doSoftReset  = 1'b0;
		doDeepDown   = 1'b0;
		doWake       = 1'b0;
		doQuadEnter  = 1'b0;
		doQuadExit   = 1'b0;
		if (execNow) begin
			doSetLatch   = (op_r == sfp_pkg::SET_WRITE_LATCH_CMD) && writeReady; // RQ14
			doClearLatch = op_r == sfp_pkg::CLEAR_WRITE_LATCH_CMD;
			// write-class needs an armed latch as well as both delays
			doWrite      = isWriteCmd(op_r) && writeReady && writeLatch; // RQ14
			doSoftReset  = (op_r == sfp_pkg::RESET_OPCODE) && rstArm_r; // RQ1
			doDeepDown   = op_r == sfp_pkg::DEEP_DOWN_CMD;
			doWake       = op_r == sfp_pkg::WAKE_CMD;
			doQuadEnter  = op_r == sfp_pkg::QUAD_ENTER_CMD;
			doQuadExit   = op_r == sfp_pkg::QUAD_EXIT_CMD;
		end
	end

	// ----------------------------------------------------------------
	// write enable latch
	// ----------------------------------------------------------------
	// actions take effect when select rises, as on a real part
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			writeLatch <= 1'b0; // RQ12
		end else if (doSetLatch) begin
			writeLatch <= 1'b1; // RQ14
		end else if (doClearLatch || doWrite || doSoftReset) begin
			// the array itself is not modelled, so a write ends at once
			writeLatch <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// modes and software reset
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			deepDown <= 1'b0; // RQ11
			quadMode <= 1'b0;
			rstArm_r <= 1'b0;
		end else if (execNow) begin
			// only the frame right after the enable frame may reset
			rstArm_r <= op_r == sfp_pkg::RESET_ENABLE_OP;
			if (doSoftReset || doWake)
				deepDown <= 1'b0;
			else if (doDeepDown)
				deepDown <= 1'b1;
			if (doSoftReset || doQuadExit)
				quadMode <= 1'b0;
			else if (doQuadEnter)
				quadMode <= 1'b1;
		end else if (csRise) begin
			// an aborted or read command still breaks the reset pair
			rstArm_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read data path
	// ----------------------------------------------------------------
	logic [7:0] romData;
	logic [7:0] outSh_r;
	logic [3:0] outCnt_r;
	logic [7:0] curByte;
	logic [7:0] statusByte;

	sfp_param_rom u_rom (
		.clock   (clock),
		.rst_n   (rst_n),
		.addr    (addr_r[7:0]),
		.inSpace (addr_r[23:8] == 16'h0000),
		.data    (romData)
	);

	assign statusByte = {6'h00, writeLatch, 1'b0};
	assign curByte    = srcStatus_r ? statusByte : romData;

	// addresses wrap over the full 24-bit space; rom answers a cycle after each step
	always_ff @(posedge clock) begin
		if (!rst_n)
			addr_r <= 24'h000000;
		else if (sclkRise && state_r == sfp_pkg::ST_DUMMY && bitCnt_r == 5'h00)
			addr_r <= inSh_r;
		else if (sclkFall && state_r == sfp_pkg::ST_DATA && outCnt_r == 4'h0)
			addr_r <= addr_r + 24'h000001;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sioOut   <= 4'h0;
			sioOe    <= 4'h0;
			outSh_r  <= 8'h00;
			outCnt_r <= 4'h0;
		// lanes let go as soon as the host deselects or readiness is lost
		end else if (csNS || !readReady || state_r != sfp_pkg::ST_DATA) begin
			sioOe    <= 4'h0;
			outCnt_r <= 4'h0;
		end else if (sclkFall) begin
			sioOe <= quadMode ? 4'hF : 4'h2;
			if (outCnt_r == 4'h0) begin
				sioOut   <= laneOut(curByte, quadMode); // RQ17
				outSh_r  <= quadMode ? {curByte[3:0], 4'h0} : {curByte[6:0], 1'b0};
				outCnt_r <= quadMode ? 4'd4 : 4'd7;
			end else begin
				sioOut   <= laneOut(outSh_r, quadMode);
				outSh_r  <= quadMode ? {outSh_r[3:0], 4'h0} : {outSh_r[6:0], 1'b0};
				outCnt_r <= outCnt_r - step[3:0];
			end
		end
	end
endmodule : sfp_flash_front

// [testbench/sfp_flash_front_assertions.sv]
// port-level checks of the flash front end
// assumes it is bound to sfp_flash_front and sees only its ports
`timescale 1ns/1ps
module sfp_flash_front_assertions #(
	parameter int unsigned WRITE_READY_CYC  = sfp_pkg::WRITE_READY_CYC,
	parameter int unsigned SELECT_READY_CYC = sfp_pkg::SELECT_READY_CYC
) (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       sclk,
	input wire logic       csN,
	input wire logic [3:0] sioIn,
	input wire logic       supplyMinOk,
	input wire logic [3:0] sioOut,
	input wire logic [3:0] sioOe,
	input wire logic       writeLatch,
	input wire logic       deepDown,
	input wire logic       quadMode,
	input wire logic       readReady,
	input wire logic       writeReady
);
	// ----
	// counters
	// ----
	int unsigned supCnt;
	int unsigned relCnt;
	// raw supply count runs ahead of the synced one, so it is a safe upper bound
	always_ff @(posedge clock) begin
		if (!supplyMinOk) supCnt <= 0;
		else if (supCnt < SELECT_READY_CYC) supCnt <= supCnt + 1;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) relCnt <= 0;
		else if (relCnt < WRITE_READY_CYC) relCnt <= relCnt + 1;
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_reset_outputs_clear: assert property ($rose(rst_n) |-> !writeLatch && !deepDown
		&& !quadMode && !readReady && sioOe == 4'h0) else $error("outputs not clear at reset");
	a_quiet_not_ready: assert property (!readReady |-> sioOe == 4'h0)
		else $error("driving before ready");
	a_read_ready_delay: assert property ($rose(readReady) |-> supCnt == SELECT_READY_CYC)
		else $error("read ready too early");
	a_write_ready_delay: assert property ($rose(writeReady) |->
		relCnt >= WRITE_READY_CYC - 1 && readReady) else $error("write ready too early");
	a_latch_needs_ready: assert property ($rose(writeLatch) |-> writeReady)
		else $error("latch set before write ready");
	a_latch_at_deselect: assert property ($changed(writeLatch) |-> csN && $past(csN))
		else $error("latch moved inside a frame");
	a_lane_mode_match: assert property (sioOe != 4'h0 |->
		sioOe == (quadMode ? 4'hF : 4'h2)) else $error("lane enables wrong for mode");
	a_released_when_idle: assert property (csN [*6] |=> sioOe == 4'h0)
		else $error("lanes driven while deselected");
	a_write_needs_read: assert property (writeReady |-> readReady)
		else $error("write ready without read ready");
endmodule : sfp_flash_front_assertions

bind sfp_flash_front sfp_flash_front_assertions #(.WRITE_READY_CYC(WRITE_READY_CYC),
	.SELECT_READY_CYC(SELECT_READY_CYC)) chk (.clock(clock), .rst_n(rst_n), .sclk(sclk),
	.csN(csN), .sioIn(sioIn), .supplyMinOk(supplyMinOk), .sioOut(sioOut), .sioOe(sioOe),
	.writeLatch(writeLatch), .deepDown(deepDown), .quadMode(quadMode),
	.readReady(readReady), .writeReady(writeReady));

// [testbench/sfp_host_model.sv]
// host serial controller model, mode 0, 125 ns serial clock
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
module sfp_host_model (
	output logic            sclk,
	output logic            csN,
	output logic      [3:0] sioIn,
	input  wire logic [3:0] sioOut,
	input  wire logic [3:0] sioOe
);
	// ----
	// serial frames
	// ----
	localparam realtime HALF = 62.5;
	logic [7:0] rd [0:31];
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		sioIn = 4'h0;
	end
	// a released lane reads inverted so a stale value never passes
	task automatic pulse(input logic [3:0] d, output logic [3:0] q);
		sioIn = d;
		#HALF sclk = 1'b1;
		for (int i = 0; i < 4; i++) q[i] = sioOe[i] ? sioOut[i] : ~sioOut[i];
		#HALF sclk = 1'b0;
	endtask : pulse
	// only 1-1-1 and 4-4-4 are ever used
	task automatic xfer(input logic [7:0] d, input bit quad, output logic [7:0] q);
		logic [3:0] n;
		if (quad) begin
			pulse(d[7:4], n);
			q[7:4] = n;
			pulse(d[3:0], n);
			q[3:0] = n;
		end else for (int b = 7; b >= 0; b--) begin
			pulse({sioIn[3:1], d[b]}, n);
			q[b] = n[1];
		end
	endtask : xfer
	task automatic close;
		#HALF csN = 1'b1;
		sioIn = ~sioIn;
		#(4 * HALF);
	endtask : close
	task automatic cmd(input logic [7:0] op, input bit quad);
		logic [7:0] q;
		csN = 1'b0;
		#HALF xfer(op, quad, q);
		close();
	endtask : cmd
	task automatic status(output logic [7:0] q);
		logic [7:0] d;
		csN = 1'b0;
		#HALF xfer(8'h05, 1'b0, d);
		xfer(8'h00, 1'b0, q);
		close();
	endtask : status
	task automatic read_table(input logic [23:0] a, input int n, input bit quad);
		logic [7:0] q;
		csN = 1'b0;
		#HALF xfer(8'h5A, quad, q);
		for (int i = 2; i >= 0; i--) xfer(a[i*8+:8], quad, q);
		for (int i = 0; i < 8; i++) pulse(~sioIn, q[3:0]);
		for (int i = 0; i < n; i++) xfer(8'hFF, quad, rd[i]);
		close();
	endtask : read_table
endmodule : sfp_host_model

// [testbench/test_sfp_flash_front.sv]
// self-checking bench of the flash front end
// assumes the host model drives the serial pins on its own timing
`timescale 1ns/1ps
module test_sfp_flash_front;
	// ----
	// harness
	// ----
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic       supplyMinOk = 1'b0;
	wire        sclk, csN, writeLatch, deepDown, quadMode, readReady, writeReady;
	wire  [3:0] sioIn, sioOut, sioOe;
	int         fails = 0;
	int         n_compared = 0;
	logic [7:0] q;
	always #5 clock = ~clock;
	// write delay long enough that a table read fits before it ends
	sfp_flash_front #(.WRITE_READY_CYC(3000), .SELECT_READY_CYC(10)) dut (.clock(clock),
		.rst_n(rst_n), .sclk(sclk), .csN(csN), .sioIn(sioIn), .supplyMinOk(supplyMinOk),
		.sioOut(sioOut), .sioOe(sioOe), .writeLatch(writeLatch), .deepDown(deepDown),
		.quadMode(quadMode), .readReady(readReady), .writeReady(writeReady));
	sfp_host_model host (.sclk(sclk), .csN(csN), .sioIn(sioIn), .sioOut(sioOut), .sioOe(sioOe));
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		@(negedge clock);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	function automatic logic [7:0] exp_byte(input logic [7:0] a);
		logic [31:0] w;
		case (a[7:2])
			6'h18:   w = 32'h16502000;
			6'h19:   w = 32'h64C0F99C;
			6'h1A:   w = 32'hFFFFC8D9;
			default: w = 32'hFFFFFFFF;
		endcase
		return w[a[1:0]*8+:8];
	endfunction : exp_byte
	task automatic finish_test;
		$display("fails=%0d n_compared=%0d", fails, n_compared);
		if (fails == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// ----
	// scenarios
	// ----
	task automatic t_power_up;
		cyc(2);
		rst_n = 1'b1;
		check(deepDown, 1'b0);
		check(writeLatch, 1'b0);
		host.cmd(8'h06, 1'b0);
		check(writeLatch, 1'b0);
	endtask : t_power_up
	task automatic t_read_early;
		cyc(1);
		supplyMinOk = 1'b1;
		for (int i = 0; i < 100 && readReady !== 1'b1; i++) cyc(1);
		check(readReady, 1'b1);
		host.read_table(24'h000060, 4, 1'b0);
		for (int i = 0; i < 4; i++) check(host.rd[i], exp_byte(8'h60 + 8'(i)));
		check(writeReady, 1'b0);
		host.cmd(8'h06, 1'b0);
		check(writeLatch, 1'b0);
	endtask : t_read_early
	task automatic t_latch;
		for (int i = 0; i < 4000 && writeReady !== 1'b1; i++) cyc(1);
		check(writeReady, 1'b1);
		host.cmd(8'h06, 1'b0);
		check(writeLatch, 1'b1);
		host.status(q);
		check(q, 8'h02);
		host.cmd(8'h99, 1'b0);
		check(writeLatch, 1'b1);
		host.cmd(8'h66, 1'b0);
		host.cmd(8'h99, 1'b0);
		check(writeLatch, 1'b0);
	endtask : t_latch
	task automatic t_table;
		host.read_table(24'h00005E, 20, 1'b0);
		for (int i = 0; i < 20; i++) check(host.rd[i], exp_byte(8'h5E + 8'(i)));
	endtask : t_table
	task automatic t_quad;
		host.cmd(8'h35, 1'b0);
		check(quadMode, 1'b1);
		host.read_table(24'h000064, 8, 1'b1);
		for (int i = 0; i < 8; i++) check(host.rd[i], exp_byte(8'h64 + 8'(i)));
		host.cmd(8'hF5, 1'b1);
		check(quadMode, 1'b0);
	endtask : t_quad
	task automatic t_deep;
		host.cmd(8'hB9, 1'b0);
		check(deepDown, 1'b1);
		host.cmd(8'h06, 1'b0);
		check(writeLatch, 1'b0);
		host.cmd(8'hAB, 1'b0);
		check(deepDown, 1'b0);
		host.cmd(8'h06, 1'b0);
		check(writeLatch, 1'b1);
		host.cmd(8'h20, 1'b0);
		check(writeLatch, 1'b0);
		host.cmd(8'h35, 1'b0);
		host.cmd(8'h66, 1'b1);
		host.cmd(8'h99, 1'b1);
		check(quadMode, 1'b0);
	endtask : t_deep
	task automatic t_reset;
		host.cmd(8'h06, 1'b0);
		check(writeLatch, 1'b1);
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		check(writeLatch, 1'b0);
		check(readReady, 1'b0);
	endtask : t_reset
	initial begin
		t_power_up();
		t_read_early();
		t_latch();
		t_table();
		t_quad();
		t_deep();
		t_reset();
		finish_test();
	end
	initial begin
		#300us;
		fails++;
		finish_test();
	end
endmodule : test_sfp_flash_front
